// file: core/four_bit_bidirectional_port.sv
// Four-pin bidirectional port with data, direction and analog select registers
`timescale 1ns/100ps
`include "gpio_port_params.svh"
//
// Functional notes
// - Direction bit one tristates the pin driver
// - Direction bit zero drives output latch value
// - Data read returns pins; write updates latch
// - Writes load wdata bits seven to four straight into latch
// - Bit six open drain; others push-pull
// - Analog-selected pins read as zero
// - Bits seven to four implemented; low zero, except analog select in bits three to zero
// - Analog select one forces read bit zero
// - Direction bits reset to one, read/write
// - Data register mirrored at two addresses
// - Direction register mirrored at two addresses
module four_bit_bidirectional_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = 4
)
(
  input  wire logic                  mclk,      // 125 MHz system clock
  input  wire logic                  rst_n,     // Asynchronous reset, active low
  input  wire logic [`ADDR_W-1:0]    addr,      // Register address
  input  wire logic [`DATA_W-1:0]    wdata,     // Write data
  input  wire logic                  wr,        // Write strobe
  input  wire logic                  rd,        // Read strobe
  output logic      [`DATA_W-1:0]    rdata,     // Read data, cycle after rd
  input  wire logic [PINS-1:0]       pinIn,     // Pin levels, asynchronous
  output logic      [PINS-1:0]       pinOut,    // Pin drive value
  output logic      [PINS-1:0]       pinOe      // Pin output enable
);

  // Logic serves the one implemented nibble only
  if (PINS != `PIN_MSB - `PIN_LSB + 1)
  begin
    $error("PINS must match the implemented nibble");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths

  function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    case (a)
      `OFF_DATA_LO, `OFF_DATA_HI: s = SEL_DATA;
      `OFF_DIR_LO, `OFF_DIR_HI:   s = SEL_DIR;
      `OFF_ANSEL:                 s = SEL_ANSEL;
      default:                    s = SEL_NONE;
    endcase
    return s;
  endfunction

  reg_sel_t                 sel;
  logic     [PINS-1:0]      pinMeta;
  logic     [PINS-1:0]      pinSync;
  logic     [PINS-1:0]      latch;
  logic     [PINS-1:0]      dir;
  logic     [PINS-1:0]      ansel;
  logic     [PINS-1:0]      pinView;
  logic     [PINS-1:0]      next_latch;
  logic     [PINS-1:0]      next_dir;
  logic     [PINS-1:0]      next_pinOut;
  logic     [PINS-1:0]      next_pinOe;

  assign sel = decode(addr);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is looked at

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // Analog pins read zero even with the digital buffer live
  assign pinView = pinSync & ~ansel;

  ////////////////////////////////////////////////////////////////////////////
  // Output latch, loaded whole on a data write

  always_comb
  begin
    // Only the implemented nibble is modifiable, so the merge is full width
    next_latch = latch;
    if (wr && sel == SEL_DATA)
      next_latch = wdata[`PIN_MSB:`PIN_LSB];
  end

  // Latch unknown at power-on in silicon; a fixed value keeps sims clean
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      latch <= `LATCH_RESET;
    else
      latch <= next_latch;
  end

  always_comb
  begin
    next_dir = dir;
    if (wr && sel == SEL_DIR)
      next_dir = wdata[`PIN_MSB:`PIN_LSB];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dir <= `DIR_RESET;
    else
      dir <= next_dir;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ansel <= `ANSEL_RESET;
    else if (wr && sel == SEL_ANSEL)
      ansel <= wdata[PINS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_comb
  begin
    next_pinOe  = ~next_dir;
    next_pinOut = next_latch;
    // Open-drain stage only sinks; a high latch releases the pin
    next_pinOe[`OD_IDX]  = ~next_dir[`OD_IDX] & ~next_latch[`OD_IDX];
    next_pinOut[`OD_IDX] = 1'b0;
  end

  // Built from next values so pins move on the write edge, still from flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut <= '0;
      pinOe  <= '0;
    end
    else
    begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after rd

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= `PORT_ZERO;
    else if (rd)
    begin
      case (sel)
        SEL_DATA:  rdata <= {pinView, 4'h0};
        SEL_DIR:   rdata <= {dir, 4'h0};
        SEL_ANSEL: rdata <= {4'h0, ansel};
        default:   rdata <= `PORT_ZERO;
      endcase
    end
    else
      rdata <= `PORT_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_dir_reset;
    @(posedge mclk) $rose(rst_n) |-> dir == `DIR_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir not reset high");

  property p_input_tristate;
    @(posedge mclk) disable iff (!rst_n) (dir & pinOe) == '0;
  endproperty
  a_input_tristate: assert property (p_input_tristate) else $error("input driven");

  property p_output_drive;
    @(posedge mclk) disable iff (!rst_n)
      !dir[1] && !(wr && sel == SEL_DIR) |=> pinOe[1] && pinOut[1] == latch[1];
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("latch not driven");

  property p_open_drain;
    @(posedge mclk) disable iff (!rst_n) pinOe[`OD_IDX] |-> !pinOut[`OD_IDX];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_analog_zero;
    @(posedge mclk) disable iff (!rst_n)
      rd && sel == SEL_DATA |=> (rdata[`PIN_MSB:`PIN_LSB] & $past(ansel)) == '0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog bit read one");

  property p_low_zero;
    @(posedge mclk) disable iff (!rst_n)
      rd && (sel == SEL_DATA || sel == SEL_DIR) |=> rdata[`PIN_LSB-1:0] == '0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low nibble nonzero");

  property p_write_latch;
    @(posedge mclk) disable iff (!rst_n)
      wr && sel == SEL_DATA |=> latch == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch missed write");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_n) !(wr && sel == SEL_DATA) |=> $stable(latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

  property p_mirror_dir;
    @(posedge mclk) disable iff (!rst_n)
      wr && addr == `OFF_DIR_HI |=> dir == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_mirror_dir: assert property (p_mirror_dir) else $error("mirror dir write lost");

  property p_mirror_data;
    @(posedge mclk) disable iff (!rst_n)
      wr && addr == `OFF_DATA_HI |=> latch == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_mirror_data: assert property (p_mirror_data) else $error("mirror data write lost");

  property p_read_pins;
    @(posedge mclk) disable iff (!rst_n)
      rd && sel == SEL_DATA |=> rdata[`PIN_MSB:`PIN_LSB] == $past(pinView);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read not pin level");

  property p_od_sink;
    @(posedge mclk) disable iff (!rst_n)
      pinOe[`OD_IDX] == (!dir[`OD_IDX] && !latch[`OD_IDX]);
  endproperty
  a_od_sink: assert property (p_od_sink) else $error("open drain enable wrong");

  property p_pin0_drive;
    @(posedge mclk) disable iff (!rst_n)
      !dir[0] |-> pinOe[0] && pinOut[0] == latch[0];
  endproperty
  a_pin0_drive: assert property (p_pin0_drive) else $error("pin four not driven");

  property p_pin3_drive;
    @(posedge mclk) disable iff (!rst_n)
      !dir[3] |-> pinOe[3] && pinOut[3] == latch[3];
  endproperty
  a_pin3_drive: assert property (p_pin3_drive) else $error("pin seven not driven");

  property p_latch_follow;
    @(posedge mclk) disable iff (!rst_n)
      pinOut[0] == latch[0] && pinOut[1] == latch[1] && pinOut[3] == latch[3];
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("drive lost latch");

  property p_dir_write;
    @(posedge mclk) disable iff (!rst_n)
      wr && sel == SEL_DIR |=> dir == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("dir missed write");

  property p_dir_hold;
    @(posedge mclk) disable iff (!rst_n)
      !(wr && sel == SEL_DIR) |=> $stable(dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir changed");

  property p_mirror_dir_lo;
    @(posedge mclk) disable iff (!rst_n)
      wr && addr == `OFF_DIR_LO |=> dir == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_mirror_dir_lo: assert property (p_mirror_dir_lo) else $error("dir write lost");

  property p_mirror_data_lo;
    @(posedge mclk) disable iff (!rst_n)
      wr && addr == `OFF_DATA_LO |=> latch == $past(wdata[`PIN_MSB:`PIN_LSB]);
  endproperty
  a_mirror_data_lo: assert property (p_mirror_data_lo) else $error("data write lost");

  property p_read_dir;
    @(posedge mclk) disable iff (!rst_n)
      rd && sel == SEL_DIR |=> rdata[`PIN_MSB:`PIN_LSB] == $past(dir);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("dir read wrong");

  property p_read_mirror_data;
    @(posedge mclk) disable iff (!rst_n)
      rd && addr == `OFF_DATA_HI |=> rdata[`PIN_MSB:`PIN_LSB] == $past(pinView);
  endproperty
  a_read_mirror_data: assert property (p_read_mirror_data) else $error("mirror read");

  property p_read_mirror_dir;
    @(posedge mclk) disable iff (!rst_n)
      rd && addr == `OFF_DIR_HI |=> rdata[`PIN_MSB:`PIN_LSB] == $past(dir);
  endproperty
  a_read_mirror_dir: assert property (p_read_mirror_dir) else $error("dir mirror");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rst_n)
      !rd |=> rdata == `PORT_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingered");

  property p_unmapped_read;
    @(posedge mclk) disable iff (!rst_n)
      rd && sel == SEL_NONE |=> rdata == `PORT_ZERO;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

  property p_unmapped_write;
    @(posedge mclk) disable iff (!rst_n)
      wr && sel == SEL_NONE |=> $stable(latch) && $stable(dir);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write");

  property p_write_only_latch;
    @(posedge mclk) disable iff (!rst_n)
      wr && sel == SEL_DATA |=> $stable(dir) && $stable(ansel);
  endproperty
  a_write_only_latch: assert property (p_write_only_latch) else $error("data write leaked");

  property p_sync_stages;
    @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(rst_n, 2) |-> pinSync == $past(pinIn, 2);
  endproperty
  a_sync_stages: assert property (p_sync_stages) else $error("pin sync depth");

  property p_ansel_write;
    @(posedge mclk) disable iff (!rst_n)
      wr && sel == SEL_ANSEL |=> ansel == $past(wdata[PINS-1:0]);
  endproperty
  a_ansel_write: assert property (p_ansel_write) else $error("analog select lost");

endmodule

// file: inc/gpio_port_params.svh
// Constants for the four-pin bidirectional port: offsets, fields, reset values
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define ADDR_W          9
`define DATA_W          8
`define OFF_DATA_LO     9'h006
`define OFF_DATA_HI     9'h106
`define OFF_DIR_LO      9'h086
`define OFF_DIR_HI      9'h186
`define OFF_ANSEL       9'h093
`define PIN_LSB         4
`define PIN_MSB         7
`define OD_IDX          2
`define DIR_RESET       4'hF
`define ANSEL_RESET     4'hF
`define LATCH_RESET     4'h0
`define PORT_ZERO       8'h00

`endif

// file: inc/gpio_port_pkg.sv
// Types shared by the port design
package gpio_port_pkg;
  typedef enum logic [1:0] {SEL_NONE, SEL_DATA, SEL_DIR, SEL_ANSEL} reg_sel_t;
endpackage

// file: tb/four_bit_bidirectional_port_tb_top.sv
// Register-level tests of the four-pin port
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module four_bit_bidirectional_port_tb_top;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] pinIn;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  logic [3:0] drvEn = 4'hF;
  logic [3:0] drvVal = 4'h5;
  int         err_total = 0;
  int         comparisons = 0;
  int         cycles = 0;
  //////////////////////////////////////////////////////////////////////
  four_bit_bidirectional_port i_four_bit_bidirectional_port
  (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  pin_board_model i_pin_board_model
  (.pinOut(pinOut), .pinOe(pinOe), .drvEn(drvEn), .drvVal(drvVal), .pinIn(pinIn));
  always #4 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdr(`OFF_DIR_LO, 8'hF0);
    rdr(`OFF_DATA_LO, 8'h00);
    rdr(`OFF_ANSEL, 8'h0F);
    rdr(9'h000, 8'h00);
    wrr(`OFF_ANSEL, 8'h00);
    drvVal <= 4'hA;
    // Two-flop pin synchroniser needs settling cycles
    repeat (3) @(posedge mclk);
    rdr(`OFF_DATA_LO, 8'hA0);
    rdr(`OFF_DATA_HI, 8'hA0);
    wrr(`OFF_DATA_HI, 8'h50);
    rdr(`OFF_DATA_LO, 8'hA0);
    chk({4'h0, pinOe}, 8'h00);
    @(posedge mclk);
    drvEn <= 4'h0;
    wrr(`OFF_DIR_HI, 8'h00);
    #1;
    chk({pinOe, pinOut}, 8'hB1);
    repeat (3) @(posedge mclk);
    rdr(`OFF_DATA_LO, 8'h50);
    wrr(`OFF_DATA_LO, 8'h00);
    #1;
    chk({pinOe, pinOut}, 8'hF0);
    rdr(`OFF_DIR_LO, 8'h00);
    wrr(`OFF_DIR_LO, 8'hF0);
    #1;
    chk({4'h0, pinOe}, 8'h00);
    @(posedge mclk);
    drvEn <= 4'hF;
    drvVal <= 4'hF;
    wrr(`OFF_ANSEL, 8'h02);
    repeat (3) @(posedge mclk);
    rdr(`OFF_DATA_HI, 8'hD0);
    wrr(9'h007, 8'h00);
    rdr(`OFF_DIR_LO, 8'hF0);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rdr(`OFF_ANSEL, 8'h0F);
    rdr(`OFF_DIR_HI, 8'hF0);
    summarize();
  end
endmodule

// file: tb/pin_board_model.sv
// Board model resolving the four port pins
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module pin_board_model
(
  input  wire logic [3:0] pinOut, // Design drive value
  input  wire logic [3:0] pinOe,  // Design drive enable
  input  wire logic [3:0] drvEn,  // Board drive enable
  input  wire logic [3:0] drvVal, // Board drive value
  output logic      [3:0] pinIn   // Resolved pin level
);
  // Open-drain pin pulled up; floating pins show inverse, never a stale level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (pinOe[i])
        pinIn[i] = pinOut[i];
      else if (drvEn[i])
        pinIn[i] = drvVal[i];
      else
        pinIn[i] = (i == `OD_IDX) ? 1'b1 : ~pinOut[i];
    end
  end
endmodule
